/* File: srcp_cmd_parser.sv */
/*
  Serial remote command front end: receives text commands, splits them into
  header path and parameter, reports each command, and sends replies.
  Assumes the instrument core consumes cmd_* pulses and feeds query answers
  on the rsp_* stream; the host keeps the line rate and format matched.
*/
// What this block does
// - seven selectable line rates, same both ends
// - eight data bits, no parity, one stop
// - terminal equipment: drive txd, sample rxd
// - header, optional parameter, then terminator
// - command identified by full node path
// - line feed ends each command message
// - every reply ends with line feed
// - header letters matched case-insensitively
// - leading whitespace before header is skipped
// - space separates header from parameter
// - abbreviations and semicolon-joined commands accepted
// - identity query answers maker, model, version
// - node matches full keyword or short form
`timescale 1ns/1ps
module srcp_cmd_parser #(
  parameter int CLK_HZ = srcp_pkg::CLK_HZ_DEF,
  parameter int DIV_W = srcp_pkg::DIV_W_DEF,
  parameter int ID_LEN = 15,
  parameter logic [8*ID_LEN-1:0] ID_STR = "XX,SIGGEN,V0.00" // arbitrary identity text
) (
  input wire logic core_clk, // 250 MHz system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [2:0] baud_sel, // line rate select
  input wire logic rxd, // serial receive data
  output logic txd, // serial transmit data
  output logic cmd_valid, // pulse, command parsed
  output logic cmd_err, // pulse, command rejected
  output logic cmd_query, // command is a query
  output logic [1:0] cmd_depth, // nodes in path
  output srcp_pkg::srcp_node_t cmd_node0, // root node index
  output srcp_pkg::srcp_node_t cmd_node1, // second node index
  output srcp_pkg::srcp_node_t cmd_node2, // third node index
  output srcp_pkg::srcp_pkind_e param_kind, // parameter form
  output logic param_bool, // parameter is 0 or 1
  output logic param_neg, // mantissa negative
  output logic [31:0] param_mant, // mantissa digits as integer
  output logic [3:0] param_frac, // digits after point
  output logic param_exp_neg, // exponent negative
  output logic [7:0] param_exp, // exponent magnitude
  input wire logic rsp_valid, // reply byte offered
  input wire logic [7:0] rsp_data, // reply byte
  input wire logic rsp_last, // last reply byte
  output logic rsp_ready // ready for a reply byte this cycle
);
  import srcp_pkg::*;

  localparam logic [DIV_W-1:0] DIV_300 = DIV_W'((CLK_HZ + BAUD_300 / 2) / BAUD_300);
  localparam logic [DIV_W-1:0] DIV_600 = DIV_W'((CLK_HZ + BAUD_600 / 2) / BAUD_600);
  localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'((CLK_HZ + BAUD_1200 / 2) / BAUD_1200);
  localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'((CLK_HZ + BAUD_2400 / 2) / BAUD_2400);
  localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'((CLK_HZ + BAUD_4800 / 2) / BAUD_4800);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);

  if ((CLK_HZ / BAUD_300) >= (2 ** DIV_W) || (CLK_HZ / BAUD_19200) < MIN_BIT_CYCLES || ID_LEN < 1 || ID_LEN > 31)
  begin : g_bad_cfg
    $error("srcp_cmd_parser: clock, divider width or identity length unusable");
  end

  typedef enum logic [2:0] {P_LEAD, P_HDR, P_SP, P_PARAM, P_TRAIL, P_BAD} srcp_pstate_e;
  typedef enum logic [1:0] {TF_IDLE, TF_IDN, TF_RSP, TF_LF} srcp_tstate_e;

  logic [DIV_W-1:0] bit_div_q;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] uc;
  logic is_ws, is_digit, is_name, is_num, is_end;
  srcp_pstate_e st_q, st_d;
  logic fin, emit, errc;
  logic [8*NODE_CHARS-1:0] nbuf_q;
  logic [3:0] nlen_q;
  srcp_node_t path_q [MAX_DEPTH];
  logic [1:0] depth_q;
  logic bad_q, qry_q, pres_q, sgn_q, dot_q, expm_q, edig_q, idn_req_q;
  logic [3:0] ndig_q;
  logic match_hit;
  srcp_node_t match_idx;
  logic fin_bad;
  logic [31:0] mant_nx;
  logic [7:0] exp_nx;

  // line rate select, unknown codes fall back to 9600
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      bit_div_q <= DIV_9600;
    else
      case (baud_sel)
        BSEL_300: bit_div_q <= DIV_300;
        BSEL_600: bit_div_q <= DIV_600;
        BSEL_1200: bit_div_q <= DIV_1200;
        BSEL_2400: bit_div_q <= DIV_2400;
        BSEL_4800: bit_div_q <= DIV_4800;
        BSEL_19200: bit_div_q <= DIV_19200;
        default: bit_div_q <= DIV_9600;
      endcase
  end

  srcp_uart_rx #(.DIV_W(DIV_W)) u_rx (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bit_div(bit_div_q),
    .rxd(rxd),
    .rx_data(rx_byte),
    .rx_valid(rx_valid),
    .rx_frame_err()
  );

  // character classes
  always_comb
  begin
    uc = (rx_byte >= CH_LA && rx_byte <= CH_LZ) ? rx_byte - CASE_GAP : rx_byte;
    is_ws = (uc == CH_SP) || (uc == CH_TAB) || (uc == CH_CR);
    is_digit = (uc >= CH_0) && (uc <= CH_9);
    is_name = is_digit || (uc >= CH_A && uc <= CH_Z) || (uc == CH_STAR);
    is_num = is_digit || (uc == CH_DOT) || (uc == CH_PLUS) || (uc == CH_MINUS) || (uc == CH_E);
    is_end = (uc == CH_SEMI) || (uc == CH_LF);
    mant_nx = (param_mant << 3) + (param_mant << 1) + {28'h0, uc[3:0]};
    exp_nx = (param_exp << 3) + (param_exp << 1) + {4'h0, uc[3:0]};
  end

  // keyword lookup on the node just collected
  always_comb
  begin
    match_hit = 1'b0;
    match_idx = '0;
    for (int i = 0; i < NODE_N; i++)
    begin
      if (node_eq(NODE_STR[i], nbuf_q, nlen_q) && nlen_q != 4'h0
          && (nlen_q == NODE_LONG[i] || nlen_q == NODE_SHORT[i]))
      begin
        match_hit = 1'b1;
        match_idx = srcp_node_t'(i);
      end
    end
    fin_bad = !match_hit || depth_q == 2'(MAX_DEPTH);
  end

  // message grammar
  always_comb
  begin
    st_d = st_q;
    fin = 1'b0;
    emit = 1'b0;
    errc = 1'b0;
    if (rx_valid)
      case (st_q)
        P_LEAD:
          if (is_name)
            st_d = P_HDR;
          else if (!(is_ws || is_end || uc == CH_COLON))
          begin
            errc = 1'b1;
            st_d = P_BAD;
          end
        P_HDR:
          if (uc == CH_COLON)
            fin = 1'b1;
          else if (uc == CH_QUERY)
          begin
            fin = 1'b1;
            st_d = P_TRAIL;
          end
          else if (is_ws)
          begin
            fin = 1'b1;
            st_d = P_SP;
          end
          else if (is_end)
          begin
            fin = 1'b1;
            emit = 1'b1;
            st_d = P_LEAD;
          end
          else if (!is_name)
          begin
            errc = 1'b1;
            st_d = P_BAD;
          end
        P_SP:
          if (is_num)
            st_d = P_PARAM;
          else if (uc == CH_QUERY)
            st_d = P_TRAIL;
          else if (is_end)
          begin
            emit = 1'b1;
            st_d = P_LEAD;
          end
          else if (!is_ws)
          begin
            errc = 1'b1;
            st_d = P_BAD;
          end
        P_PARAM, P_TRAIL:
          if (is_end)
          begin
            emit = 1'b1;
            st_d = P_LEAD;
          end
          else if (is_ws)
            st_d = P_TRAIL;
          else if (!(st_q == P_PARAM && is_num))
          begin
            errc = 1'b1;
            st_d = P_BAD;
          end
        P_BAD:
          if (is_end)
          begin
            emit = 1'b1;
            st_d = P_LEAD;
          end
        default:
          st_d = P_LEAD;
      endcase
  end

  // header and parameter collection, command report
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_q <= P_LEAD;
      nbuf_q <= '0;
      nlen_q <= '0;
      path_q <= '{default: '0};
      depth_q <= '0;
      {bad_q, qry_q, pres_q, sgn_q, dot_q, expm_q, edig_q, idn_req_q} <= '0;
      ndig_q <= '0;
      {cmd_valid, cmd_err, cmd_query, param_bool, param_neg, param_exp_neg} <= '0;
      cmd_depth <= '0;
      {cmd_node0, cmd_node1, cmd_node2} <= '0;
      param_kind <= PK_NONE;
      param_mant <= '0;
      param_frac <= '0;
      param_exp <= '0;
    end
    else
    begin
      st_q <= st_d;
      cmd_valid <= 1'b0;
      cmd_err <= 1'b0;
      idn_req_q <= 1'b0;
      if (rx_valid)
      begin
        if (st_q == P_LEAD && st_d == P_HDR)
        begin
          nbuf_q <= {uc, {(8*NODE_CHARS-8){1'b0}}};
          nlen_q <= 4'h1;
        end
        if (st_q == P_HDR && is_name)
        begin
          if (nlen_q == 4'(NODE_CHARS))
            bad_q <= 1'b1;
          else
          begin
            nbuf_q[8*(NODE_CHARS-1-int'(nlen_q)) +: 8] <= uc;
            nlen_q <= nlen_q + 4'h1;
          end
        end
        if (fin)
        begin
          if (!fin_bad)
          begin
            path_q[depth_q] <= match_idx;
            depth_q <= depth_q + 2'h1;
          end
          bad_q <= bad_q | fin_bad;
          nlen_q <= '0;
        end
        if (uc == CH_QUERY && (st_q == P_HDR || st_q == P_SP))
          qry_q <= 1'b1;
        if (errc)
          bad_q <= 1'b1;
        if (st_d == P_PARAM && (st_q == P_SP || st_q == P_PARAM))
        begin
          pres_q <= 1'b1;
          if (is_digit && expm_q)
          begin
            param_exp <= exp_nx;
            edig_q <= 1'b1;
          end
          else if (is_digit)
          begin
            param_mant <= mant_nx;
            ndig_q <= (ndig_q == 4'hF) ? ndig_q : ndig_q + 4'h1;
            if (dot_q)
              param_frac <= (param_frac == 4'hF) ? param_frac : param_frac + 4'h1;
          end
          else if (uc == CH_DOT)
          begin
            bad_q <= bad_q | dot_q | expm_q;
            dot_q <= 1'b1;
          end
          else if (uc == CH_E)
          begin
            bad_q <= bad_q | expm_q | (ndig_q == 4'h0);
            expm_q <= 1'b1;
          end
          else if (expm_q)
          begin
            bad_q <= bad_q | edig_q;
            param_exp_neg <= (uc == CH_MINUS);
          end
          else
          begin
            bad_q <= bad_q | sgn_q | dot_q | (ndig_q != 4'h0);
            sgn_q <= 1'b1;
            param_neg <= (uc == CH_MINUS);
          end
        end
        if (emit)
        begin
          cmd_err <= bad_q | errc | (fin && fin_bad) | (pres_q && ndig_q == 4'h0) | (expm_q && !edig_q);
          cmd_valid <= !(bad_q | errc | (fin && fin_bad) | (pres_q && ndig_q == 4'h0) | (expm_q && !edig_q));
          cmd_query <= qry_q;
          cmd_depth <= depth_q + {1'b0, fin};
          cmd_node0 <= (fin && depth_q == 2'h0) ? match_idx : path_q[0];
          cmd_node1 <= (fin && depth_q == 2'h1) ? match_idx : path_q[1];
          cmd_node2 <= (fin && depth_q == 2'h2) ? match_idx : path_q[2];
          param_kind <= !pres_q ? PK_NONE : expm_q ? PK_NR3 : dot_q ? PK_NR2 : PK_NR1;
          param_bool <= pres_q && !expm_q && !dot_q && !sgn_q && ndig_q == 4'h1 && param_mant <= 32'h1;
          idn_req_q <= !bad_q && qry_q && depth_q == 2'h1 && path_q[0] == NODE_IDN;
          nlen_q <= '0;
          depth_q <= '0;
          path_q <= '{default: '0};
          {bad_q, qry_q, pres_q, sgn_q, dot_q, expm_q, edig_q} <= '0;
          ndig_q <= '0;
        end
        if (st_q != P_PARAM && st_d == P_PARAM)
        begin
          param_mant <= is_digit ? {28'h0, uc[3:0]} : 32'h0;
          param_frac <= '0;
          param_exp <= '0;
          param_neg <= (uc == CH_MINUS);
          param_exp_neg <= 1'b0;
          ndig_q <= is_digit ? 4'h1 : 4'h0;
          dot_q <= (uc == CH_DOT);
          sgn_q <= (uc == CH_PLUS) || (uc == CH_MINUS);
          bad_q <= bad_q | (uc == CH_E);
        end
      end
    end
  end

  // reply feeder and transmitter
  srcp_tstate_e tf_q;
  logic idn_pend_q;
  logic [4:0] idn_ptr_q;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [8:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic [DIV_W-1:0] tx_cnt_q;
  logic tx_busy_q;

  always_comb
  begin
    tx_load = 1'b0;
    tx_byte = CH_LF;
    case (tf_q)
      TF_IDN:
      begin
        tx_load = !tx_busy_q;
        tx_byte = ID_STR[8*(ID_LEN-1-int'(idn_ptr_q)) +: 8];
      end
      TF_RSP:
      begin
        tx_load = rsp_valid && rsp_ready;
        tx_byte = rsp_data;
      end
      TF_LF:
        tx_load = !tx_busy_q;
      default:
        tx_load = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      tf_q <= TF_IDLE;
      idn_pend_q <= 1'b0;
      idn_ptr_q <= '0;
      rsp_ready <= 1'b0;
    end
    else
    begin
      idn_pend_q <= idn_req_q || (idn_pend_q && tf_q != TF_IDLE); // request wins over clear
      rsp_ready <= (tf_q == TF_RSP) && !tx_busy_q && !tx_load && !(rsp_ready && rsp_valid);
      case (tf_q)
        TF_IDLE:
          if (idn_pend_q)
          begin
            tf_q <= TF_IDN;
            idn_ptr_q <= '0;
          end
          else if (rsp_valid)
            tf_q <= TF_RSP;
        TF_IDN:
          if (tx_load)
          begin
            idn_ptr_q <= idn_ptr_q + 5'h1;
            if (idn_ptr_q == 5'(ID_LEN - 1))
              tf_q <= TF_LF;
          end
        TF_RSP:
          if (tx_load && rsp_last)
            tf_q <= TF_LF;
        TF_LF:
          if (tx_load)
            tf_q <= TF_IDLE;
        default:
          tf_q <= TF_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      txd <= 1'b1;
      tx_shift_q <= '1;
      tx_bits_q <= '0;
      tx_cnt_q <= '0;
      tx_busy_q <= 1'b0;
    end
    else if (tx_load)
    begin
      txd <= 1'b0;
      tx_shift_q <= {1'b1, tx_byte};
      tx_bits_q <= TX_SHIFT_BITS;
      tx_cnt_q <= bit_div_q - 1'b1;
      tx_busy_q <= 1'b1;
    end
    else if (tx_busy_q)
    begin
      if (tx_cnt_q != '0)
        tx_cnt_q <= tx_cnt_q - 1'b1;
      else if (tx_bits_q == 4'h0)
        tx_busy_q <= 1'b0;
      else
      begin
        txd <= tx_shift_q[0];
        tx_shift_q <= {1'b1, tx_shift_q[8:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_cnt_q <= bit_div_q - 1'b1;
      end
    end
  end

  function automatic logic node_eq(input logic [8*NODE_CHARS-1:0] key, input logic [8*NODE_CHARS-1:0] got,
                                   input logic [3:0] len);
    logic eq;
    eq = 1'b1;
    for (int k = 0; k < NODE_CHARS; k++)
      if (k < int'(len) && key[8*(NODE_CHARS-1-k) +: 8] != got[8*(NODE_CHARS-1-k) +: 8])
        eq = 1'b0;
    return eq;
  endfunction : node_eq

endmodule : srcp_cmd_parser

/* File: srcp_pkg.sv */
/*
  Shared constants for the serial remote command parser: clock and line rates,
  character codes, the command keyword table and the parameter kinds.
  Assumes a single 250 MHz core clock and 8-N-1 asynchronous serial framing.
*/
package srcp_pkg;

  // clock and line rates
  localparam int CLK_HZ_DEF = 250_000_000;
  localparam int BAUD_300 = 300;
  localparam int BAUD_600 = 600;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int MIN_BIT_CYCLES = 16;
  localparam int DIV_W_DEF = 20;

  // baud select encoding
  localparam logic [2:0] BSEL_300 = 3'h0;
  localparam logic [2:0] BSEL_600 = 3'h1;
  localparam logic [2:0] BSEL_1200 = 3'h2;
  localparam logic [2:0] BSEL_2400 = 3'h3;
  localparam logic [2:0] BSEL_4800 = 3'h4;
  localparam logic [2:0] BSEL_9600 = 3'h5;
  localparam logic [2:0] BSEL_19200 = 3'h6;

  // character framing
  localparam int DATA_BITS = 8;
  localparam logic [3:0] TX_SHIFT_BITS = 4'h9;

  // character codes
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_GAP = 8'h20;

  // keyword table
  localparam int NODE_CHARS = 10;
  localparam int NODE_N = 28;
  localparam int MAX_DEPTH = 3;
  typedef logic [4:0] srcp_node_t;
  localparam srcp_node_t NODE_IDN = 5'h01;
  localparam logic [8*NODE_CHARS-1:0] NODE_STR [NODE_N] = '{
    "*CLS      ", "*IDN      ", "*RCL      ", "*SAV      ", "*RST      ", "SYSTEM    ", "ERR       ",
    "FUNCTION  ", "WAVEFORM  ", "FREQUENCY ", "AMPLITUDE ", "VOLTAGE   ", "UNIT      ", "OFFSET    ",
    "DUTY      ", "SOURCE    ", "STATE     ", "MODAM     ", "MODFM     ", "RATE      ", "SPAN      ",
    "SYM       ", "SWEEP     ", "START     ", "STOP      ", "CENTER    ", "SPACING   ", "TRIGGER   "};
  localparam logic [3:0] NODE_LONG [NODE_N] = '{
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h6, 4'h3, 4'h8, 4'h8, 4'h9, 4'h9, 4'h7, 4'h4, 4'h6,
    4'h4, 4'h6, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h3, 4'h5, 4'h5, 4'h4, 4'h6, 4'h7, 4'h7};
  localparam logic [3:0] NODE_SHORT [NODE_N] = '{
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h4, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
    4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h3, 4'h4, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4};

  // parameter kinds: none, integer, decimal, exponent form
  typedef enum logic [1:0] {PK_NONE, PK_NR1, PK_NR2, PK_NR3} srcp_pkind_e;

endpackage : srcp_pkg

/* File: srcp_uart_rx.sv */
/*
  Asynchronous serial receiver, 8 data bits, no parity, one stop bit.
  Assumes rxd is already synchronous to core_clk and bit_div holds clocks per bit.
*/
`timescale 1ns/1ps
module srcp_uart_rx #(
  parameter int DIV_W = srcp_pkg::DIV_W_DEF
) (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [DIV_W-1:0] bit_div, // clocks per bit
  input wire logic rxd, // serial line in, idles high
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // one-cycle pulse, byte good
  output logic rx_frame_err // one-cycle pulse, stop bit low
);
  import srcp_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} srcp_rx_state_e;

  srcp_rx_state_e st_q;
  logic [DIV_W-1:0] cnt_q;
  logic [2:0] bit_q;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      rx_frame_err <= 1'b0;
      if (cnt_q != '0)
        cnt_q <= cnt_q - 1'b1;
      case (st_q)
        RX_IDLE:
          if (!rxd)
          begin
            st_q <= RX_START;
            cnt_q <= bit_div >> 1;
          end
        RX_START:
          if (cnt_q == '0)
          begin
            if (rxd)
              st_q <= RX_IDLE; // glitch, not a start bit
            else
            begin
              st_q <= RX_DATA;
              cnt_q <= bit_div - 1'b1;
              bit_q <= '0;
            end
          end
        RX_DATA:
          if (cnt_q == '0)
          begin
            rx_data <= {rxd, rx_data[7:1]};
            cnt_q <= bit_div - 1'b1;
            bit_q <= bit_q + 1'b1;
            if (bit_q == 3'(DATA_BITS - 1))
              st_q <= RX_STOP;
          end
        RX_STOP:
          if (cnt_q == '0)
          begin
            rx_valid <= rxd;
            rx_frame_err <= !rxd;
            st_q <= RX_IDLE;
          end
        default:
          st_q <= RX_IDLE;
      endcase
    end
  end

endmodule : srcp_uart_rx

/* File: srcp_cmd_parser_asserts.sv */
/* Port checker for the serial command parser.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module srcp_cmd_parser_asserts (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic txd, // serial out
  input wire logic cmd_valid, // report ok
  input wire logic cmd_err, // report bad
  input wire logic cmd_query, // query flag
  input wire logic [1:0] cmd_depth, // path depth
  input wire srcp_pkg::srcp_node_t cmd_node0, // root node
  input wire srcp_pkg::srcp_node_t cmd_node1, // node two
  input wire srcp_pkg::srcp_pkind_e param_kind, // param form
  input wire logic param_bool, // bool flag
  input wire logic [31:0] param_mant, // mantissa
  input wire logic [3:0] param_frac, // fraction digits
  input wire logic rsp_valid, // reply offered
  input wire logic rsp_ready // reply taken
);
  import srcp_pkg::*;
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_report_exclusive: assert property (!(cmd_valid && cmd_err))
    else $error("valid and error together");
  a_valid_single: assert property (cmd_valid |=> !cmd_valid)
    else $error("valid longer than one cycle");
  a_reset_quiet: assert property ($rose(reset_n) |-> txd && !rsp_ready && param_kind == PK_NONE)
    else $error("outputs not quiet after reset");
  a_start_width: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  a_depth_legal: assert property (cmd_valid |-> cmd_depth != 2'h0 && (cmd_depth > 2'h1 || cmd_node1 == 5'h00))
    else $error("bad path depth");
  a_idn_answer: assert property (cmd_valid && cmd_query && cmd_depth == 2'h1 && cmd_node0 == NODE_IDN
    |-> ##[1:8] $fell(txd)) else $error("identity reply late");
  a_take_starts: assert property (rsp_valid && rsp_ready |=> !rsp_ready && !txd)
    else $error("taken byte not started");
  a_ready_holds: assert property (rsp_ready && !rsp_valid |=> rsp_ready)
    else $error("ready dropped untaken");
  a_nr1_whole: assert property (cmd_valid && param_kind == PK_NR1 |-> param_frac == 4'h0
    && (!param_bool || param_mant <= 32'h1)) else $error("integer form wrong");
  c_idn: cover property (cmd_valid && cmd_query && cmd_node0 == NODE_IDN);
  c_err: cover property (cmd_err);
  c_take: cover property (rsp_valid && rsp_ready);
endmodule : srcp_cmd_parser_asserts

bind srcp_cmd_parser srcp_cmd_parser_asserts srcp_cmd_parser_asserts_inst (.core_clk(core_clk),
  .reset_n(reset_n), .txd(txd), .cmd_valid(cmd_valid), .cmd_err(cmd_err), .cmd_query(cmd_query),
  .cmd_depth(cmd_depth), .cmd_node0(cmd_node0), .cmd_node1(cmd_node1), .param_kind(param_kind),
  .param_bool(param_bool), .param_mant(param_mant), .param_frac(param_frac), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready));

/* File: srcp_host_model.sv */
/* Host terminal model: sends command text, collects reply bytes.
   Assumes 8-N-1 framing at div core clocks per bit, set to match. */
`timescale 1ns/1ps
module srcp_host_model (
  input wire logic core_clk, // system clock
  input wire logic txd, // device transmit line
  input wire logic [31:0] div, // clocks per bit
  output logic rxd // device receive line
);
  logic [7:0] rx_q[$];
  initial rxd = 1'h1; // idle high
  task send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'h0}; // start, lsb first, one stop
    for (int i = 0; i < 11; i++)
    begin
      @(posedge core_clk) rxd <= (i < 10) ? f[i] : 1'h1;
      repeat (div - 1) @(posedge core_clk);
    end
  endtask : send_byte
  task send_str(input string s);
    for (int i = 0; i < s.len(); i++)
      send_byte(s[i], 1'h1);
  endtask : send_str
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(negedge core_clk);
      if (txd === 1'h0)
      begin
        repeat (div / 2) @(negedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (div) @(negedge core_clk);
          b[i] = txd;
        end
        repeat (div) @(negedge core_clk);
        if (txd === 1'h1)
          rx_q.push_back(b); // mid-bit sampling
      end
    end
  end
endmodule : srcp_host_model

/* File: tb_top.sv */
/* Testbench for the serial command parser with a host terminal model.
   Assumes a shortened CLK_HZ so one bit lasts 16 clocks at 19200. */
`timescale 1ns/1ps
module tb_top;
  import srcp_pkg::*;
  localparam int CLK_HZ = 307200;
  localparam logic [119:0] ID_V = "QR,WAVGEN,V9.99"; // arbitrary identity text
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] baud_sel = BSEL_19200;
  logic rsp_valid = 1'h0;
  logic rsp_last = 1'h0;
  logic [7:0] rsp_data = 8'h00;
  logic rxd, txd, cmd_valid, cmd_err, cmd_query, param_bool, param_neg, param_exp_neg, rsp_ready;
  logic [1:0] cmd_depth;
  srcp_node_t cmd_node0, cmd_node1, cmd_node2;
  srcp_pkind_e param_kind;
  logic [31:0] param_mant;
  logic [3:0] param_frac;
  logic [7:0] param_exp;
  int div = CLK_HZ / 19200;
  int err_total = 0;
  int n_compared = 0;
  logic [67:0] rep_q[$];
  logic [67:0] r;
  always #2 core_clk = ~core_clk;
  srcp_cmd_parser #(.CLK_HZ(CLK_HZ), .ID_STR(ID_V)) srcp_cmd_parser_inst (.core_clk(core_clk),
    .reset_n(reset_n), .baud_sel(baud_sel), .rxd(rxd), .txd(txd), .cmd_valid(cmd_valid), .cmd_err(cmd_err),
    .cmd_query(cmd_query), .cmd_depth(cmd_depth), .cmd_node0(cmd_node0), .cmd_node1(cmd_node1),
    .cmd_node2(cmd_node2), .param_kind(param_kind), .param_bool(param_bool), .param_neg(param_neg),
    .param_mant(param_mant), .param_frac(param_frac), .param_exp_neg(param_exp_neg), .param_exp(param_exp),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
  srcp_host_model srcp_host_model_inst (.core_clk(core_clk), .txd(txd), .div(div), .rxd(rxd));
  always @(negedge core_clk)
    if (cmd_valid === 1'h1 || cmd_err === 1'h1)
      rep_q.push_back({cmd_err, cmd_query, cmd_depth, cmd_node0, cmd_node1, cmd_node2, param_kind,
        param_bool, param_neg, param_mant, param_frac, param_exp_neg, param_exp});
  task print_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task check(input string what, input logic [67:0] seen, input logic [67:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wait_for(input int nr, input int nb);
    int k;
    k = 0;
    while ((rep_q.size() < nr || srcp_host_model_inst.rx_q.size() < nb) && k < 40000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k == 40000)
    begin
      err_total++;
      print_verdict();
    end
  endtask : wait_for
  task send(input string s);
    srcp_host_model_inst.send_str(s);
    wait_for(1, 0);
    r = rep_q.pop_front();
  endtask : send
  task check_reply(input logic [127:0] s, input int n);
    wait_for(0, n);
    for (int i = 0; i < n; i++)
      check("reply byte", srcp_host_model_inst.rx_q.pop_front(), s[8*(n-1-i)+:8]);
  endtask : check_reply
  task sc_identity;
    srcp_host_model_inst.send_byte(8'h58, 1'h0); // bad stop, dropped
    send(" *idn?\n");
    check("idn header", r[67:49], {4'h5, NODE_IDN, 10'h000});
    check_reply({ID_V, CH_LF}, 16);
  endtask : sc_identity
  task sc_path;
    send("Sour:SWE:spac 1\n");
    check("path", r[67:49], {4'h3, 5'h0F, 5'h16, 5'h1A});
    check("param", r[48:0], {PK_NR1, 2'h2, 32'h1, 13'h0000});
  endtask : sc_path
  task sc_joined;
    send("freq 1.5;ampl:volt -4.5E-1\n");
    check("first", r[67:49], {4'h1, 5'h09, 10'h000});
    check("first param", r[48:0], {PK_NR2, 2'h0, 32'hF, 4'h1, 9'h000});
    wait_for(1, 0);
    r = rep_q.pop_front();
    check("second", r[67:49], {4'h2, 5'h0A, 5'h0B, 5'h00});
    check("second param", r[48:0], {PK_NR3, 2'h1, 32'h2D, 4'h1, 9'h101});
  endtask : sc_joined
  task sc_error;
    send("\nfoo 2\n");
    check("error", r[67], 1'h1);
  endtask : sc_error
  task sc_reply;
    int k;
    @(posedge core_clk);
    for (int i = 0; i < 2; i++)
    begin
      rsp_valid <= 1'h1;
      rsp_data <= (i == 0) ? 8'h6F : 8'h6B;
      rsp_last <= (i == 1);
      @(negedge core_clk);
      for (k = 0; k < 5000 && rsp_ready !== 1'h1; k++)
        @(negedge core_clk);
      if (k == 5000)
      begin
        err_total++;
        print_verdict();
      end
      @(posedge core_clk);
    end
    rsp_valid <= 1'h0;
    rsp_last <= 1'h0;
    check_reply({16'h6F6B, CH_LF}, 3);
  endtask : sc_reply
  task sc_baud;
    repeat (64) @(posedge core_clk);
    baud_sel <= BSEL_9600;
    div = CLK_HZ / 9600;
    send("*IDN?\n");
    check("idn at 9600", r[67:49], {4'h5, NODE_IDN, 10'h000});
    check_reply({ID_V, CH_LF}, 16);
  endtask : sc_baud
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    sc_identity();
    sc_path();
    sc_joined();
    sc_error();
    sc_reply();
    sc_baud();
    check("spare reports", rep_q.size(), 68'h0);
    print_verdict();
  end
endmodule : tb_top
